// ---- hw/autoneg_consts.svh ----
`ifndef AUTONEG_CONSTS_SVH
`define AUTONEG_CONSTS_SVH

`define ADV_REG_INDEX 8'h04
`define ADV_REG_ADDR 32'h0000_0010
`define RESTART_REG_ADDR 32'h0000_0000
`define ADV_RESET 16'h01E1
`define ADV_PAGE_RESET 11'h1E1
`define ADV_WRITE_MASK 16'h21E0
`define ADV_SELECTOR 5'h01
`define ADV_NP_BIT 15
`define ADV_RF_BIT 13
`define ADV_A3_BIT 8
`define ADV_A2_BIT 7
`define ADV_A1_BIT 6
`define ADV_A0_BIT 5
`define RESTART_BIT 0
`define STAT_ACTIVE_BIT 1

`endif

// ---- hw/autoneg_pkg.sv ----
package autoneg_pkg;
   typedef struct packed {
      logic next_page_capable;
      logic remote_fault_advert;
      logic ability_100_full;
      logic ability_100_half;
      logic ability_10_full;
      logic ability_10_half;
      logic [4:0] selector;
   } adv_page_t;

   typedef struct packed {
      logic sel;
      logic write;
      logic [31:0] addr;
   } ahb_cmd_t;
endpackage

// ---- hw/adv_word_pack.sv ----
`timescale 1ns/1ps
`include "autoneg_consts.svh"
module adv_word_pack
   import autoneg_pkg::*;
(
   input wire logic [15:0] i_word,
   output adv_page_t o_page
);
   // Selector and next page are fixed, never taken from the stored word
   assign o_page.next_page_capable = 1'b0; // RULE4
   assign o_page.remote_fault_advert = i_word[`ADV_RF_BIT]; // RULE11
   assign o_page.ability_100_full = i_word[`ADV_A3_BIT]; // RULE10
   assign o_page.ability_100_half = i_word[`ADV_A2_BIT]; // RULE5
   assign o_page.ability_10_full = i_word[`ADV_A1_BIT]; // RULE6
   assign o_page.ability_10_half = i_word[`ADV_A0_BIT]; // RULE10
   assign o_page.selector = `ADV_SELECTOR; // RULE9
endmodule

// ---- hw/autoneg_advertisement_register.sv ----
`timescale 1ns/1ps
`include "autoneg_consts.svh"
// Behaviour
// RULE1 - The advertised page sent to the partner is taken from this register.
// RULE2 - Bits 8 to 5 hold the technology abilities and software may write them.
// RULE3 - A write only reaches the advertised page when negotiation is restarted.
// RULE4 - Bit 15 is the read-only next-page flag and reads as 0 after reset.
// RULE5 - Bit 7 set advertises 100 Mb/s half duplex and resets to 1.
// RULE6 - Bit 6 set advertises 10 Mb/s full duplex and resets to 1.
// RULE7 - Software keeps a mode out by clearing its bit and restarting negotiation.
// RULE8 - The register resets to 0x01E1.
// RULE9 - Bits 4 to 0 are the read-only selector, fixed at 0x01.
// RULE10 - Bit 8 advertises 100 full, bit 5 10 half; both writable, reset to 1.
// RULE11 - Bit 13 is the writable remote-fault flag, reset to 0, sent in the page.
module autoneg_advertisement_register
   import autoneg_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic i_restart_done,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic o_restart_pulse,
   output adv_page_t o_adv_page
);
   logic rst_meta;
   logic rst_sync_n;
   ahb_cmd_t cmd;
   logic [15:0] adv_word;
   logic [15:0] live_word;
   logic restart_active;
   logic [31:0] rdata;
   adv_page_t live_page;
   adv_page_t next_adv_page;

   wire addr_phase = i_hsel && i_htrans[1] && i_hready;
   wire wr_adv = cmd.sel && cmd.write && (cmd.addr == `ADV_REG_ADDR);
   wire wr_restart = cmd.sel && cmd.write && (cmd.addr == `RESTART_REG_ADDR);
   wire restart_req = wr_restart && i_hwdata[`RESTART_BIT];
   wire [15:0] next_adv_word = wr_adv ?
      ((adv_word & ~`ADV_WRITE_MASK) | (i_hwdata[15:0] & `ADV_WRITE_MASK)) :
      adv_word; // RULE2
   wire rd_adv = addr_phase && !i_hwrite && (i_haddr == `ADV_REG_ADDR);
   wire rd_stat = addr_phase && !i_hwrite && (i_haddr == `RESTART_REG_ADDR);

   // Read-only bits come from the packer, so software never sees them move
   adv_word_pack u_pack (
      .i_word(adv_word),
      .o_page(live_page)
   );

   assign live_word = {live_page.next_page_capable, 1'b0,
                       live_page.remote_fault_advert, 4'h0,
                       live_page.ability_100_full, live_page.ability_100_half,
                       live_page.ability_10_full, live_page.ability_10_half,
                       live_page.selector}; // RULE4 RULE9

   always_comb begin
      rdata = 32'h0000_0000;
      if (rd_adv) begin
         rdata = {16'h0000, live_word};
      end else if (rd_stat) begin
         rdata[`STAT_ACTIVE_BIT] = restart_active;
      end
   end

   // Page seen by the partner latches only on restart
   always_comb begin
      next_adv_page = o_adv_page;
      if (restart_req) begin
         next_adv_page = live_page; // RULE3 RULE7
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmd <= '0;
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         cmd.sel <= addr_phase;
         cmd.write <= i_hwrite;
         cmd.addr <= i_haddr;
         o_hrdata <= rdata;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         adv_word <= `ADV_RESET; // RULE8
         o_adv_page <= `ADV_PAGE_RESET; // RULE8
         o_restart_pulse <= 1'b0;
         restart_active <= 1'b0;
      end else begin
         adv_word <= next_adv_word;
         o_adv_page <= next_adv_page; // RULE1
         o_restart_pulse <= restart_req;
         // New restart wins over a done in the same cycle
         restart_active <= restart_req | (restart_active & ~i_restart_done);
      end
   end
endmodule

// ---- sim/adv_monitor.sv ----
`timescale 1ns/1ps
module adv_monitor import autoneg_pkg::*; (
   input wire logic i_ref_clk, i_rst_n, i_hsel, i_hwrite, o_restart_pulse,
   input wire logic [1:0] i_htrans,
   input wire logic [31:0] i_haddr, i_hwdata, o_hrdata,
   input wire adv_page_t o_adv_page
);
   logic [3:0] ph;
   // Zero wait states, so hready plays no part in the capture
   wire kick = ph[3:1] == 3'h7 && i_hwdata[0];
   wire rd = ph[3:2] == 2'h1 && ph[0];
   always_ff @(posedge i_ref_clk) ph <= {i_hwrite, i_hsel & i_htrans[1], i_haddr == 32'h0,
      i_haddr == 32'h10};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   property p_np; !o_adv_page.next_page_capable; endproperty
   a_np: assert property (p_np) else $error("next page flag set");
   property p_sel; o_adv_page.selector == 5'h01; endproperty
   a_sel: assert property (p_sel) else $error("selector wrong");
   property p_rst; $rose(i_rst_n) |-> o_adv_page == 11'h1E1; endproperty
   a_rst: assert property (p_rst) else $error("page reset value wrong");
   property p_hold; $changed(o_adv_page) |-> o_restart_pulse || $past(o_restart_pulse); endproperty
   a_hold: assert property (p_hold) else $error("page moved without restart");
   property p_kick; kick |-> ##[1:2] o_restart_pulse; endproperty
   a_kick: assert property (p_kick) else $error("restart not issued");
   property p_cause; o_restart_pulse |-> $past(kick) || $past(kick, 2); endproperty
   a_cause: assert property (p_cause) else $error("restart without request");
   property p_one; o_restart_pulse |=> !o_restart_pulse; endproperty
   a_one: assert property (p_one) else $error("restart pulse too long");
   property p_rd; rd |-> (o_hrdata & 32'hFFFF_DE1F) == 32'h0000_0001; endproperty
   a_rd: assert property (p_rd) else $error("read-only bits wrong");
   c_kick: cover property (kick);
   c_page: cover property ($changed(o_adv_page));
   c_rd: cover property (rd);
endmodule
bind autoneg_advertisement_register adv_monitor adv_monitor_inst (.*);

// ---- sim/autoneg_engine_model.sv ----
`timescale 1ns/1ps
module autoneg_engine_model import autoneg_pkg::*; (
   input wire logic i_ref_clk, i_restart,
   input wire logic [3:0] i_dly,
   input wire adv_page_t i_page,
   output logic o_done = 1'h0,
   output adv_page_t o_seen
);
   logic [3:0] cnt = 4'h0;
   // Page is taken late, once the restart has surely landed
   always_ff @(posedge i_ref_clk) begin
      cnt <= i_restart ? i_dly : cnt - 4'(cnt != 4'h0);
      o_done <= cnt == 4'h1;
      if (cnt == 4'h1) o_seen <= i_page;
   end
endmodule

// ---- sim/autoneg_advertisement_register_tb.sv ----
`timescale 1ns/1ps
module autoneg_advertisement_register_tb import autoneg_pkg::*; ;
   logic i_ref_clk = 1'h0, i_rst_n = 1'h0, i_hsel = 1'h1, i_hwrite = 1'h0;
   logic i_restart_done, o_hreadyout, o_hresp, o_restart_pulse;
   logic [1:0] i_htrans = 2'h0;
   logic [2:0] i_hsize = 3'h2;
   logic [3:0] dly = 4'hA;
   logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, r;
   adv_page_t o_adv_page, seen;
   int errors = 0, num_checks = 0;
   autoneg_advertisement_register autoneg_advertisement_register_inst (.*,
      .i_hready(o_hreadyout));
   autoneg_engine_model autoneg_engine_model_inst (.i_ref_clk, .i_restart(o_restart_pulse),
      .i_dly(dly), .i_page(o_adv_page), .o_done(i_restart_done), .o_seen(seen));
   initial forever #2 i_ref_clk = ~i_ref_clk;
   task give_verdict(input int e);
      errors += e;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      errors += int'(s !== e);
      if (s !== e) $display("[ERR] %0t got %h want %h", $time, s, e);
   endtask
   task automatic wt(ref logic s);
      int n = 0;
      do @(posedge i_ref_clk); while (s !== 1'h1 && ++n < 40);
      if (n == 40) give_verdict(1);
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      i_htrans <= 2'h2;
      i_hwrite <= w;
      i_haddr <= a;
      wt(o_hreadyout);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      wt(o_hreadyout);
      r = o_hrdata;
   endtask
   task t_regs;
      xfer(1'h0, 32'h10, 32'h0);
      chk(r, 32'h0000_01E1);
      chk(32'(o_hresp), 32'h0);
      xfer(1'h1, 32'h10, 32'hFFFF_FFFF);
      xfer(1'h1, 32'h20, 32'h0000_0005);
      xfer(1'h0, 32'h10, 32'h0);
      chk(r, 32'h0000_21E1);
      xfer(1'h0, 32'h20, 32'h0);
      chk(r, 32'h0);
      chk(32'(o_adv_page), 32'h0000_01E1);
      $display("t_regs done");
   endtask
   task t_slow;
      xfer(1'h1, 32'h0, 32'h0000_0001);
      xfer(1'h0, 32'h0, 32'h0);
      chk(r & 32'h0000_0002, 32'h0000_0002);
      wt(i_restart_done);
      chk(32'(seen), 32'h0000_03E1);
      xfer(1'h0, 32'h0, 32'h0);
      chk(r & 32'h0000_0002, 32'h0);
      $display("t_slow done");
   endtask
   task t_fast;
      dly <= 4'h1;
      xfer(1'h1, 32'h10, 32'h0000_0140);
      xfer(1'h1, 32'h0, 32'h0000_0001);
      wt(i_restart_done);
      chk(32'(seen), 32'h0000_0141);
      $display("t_fast done");
   endtask
   task t_reset;
      i_rst_n <= 1'h0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'h1;
      repeat (3) @(posedge i_ref_clk);
      chk(32'(o_adv_page), 32'h0000_01E1);
      xfer(1'h0, 32'h10, 32'h0);
      chk(r, 32'h0000_01E1);
      $display("t_reset done");
   endtask
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'h1;
      repeat (3) @(posedge i_ref_clk);
      t_regs();
      t_slow();
      t_fast();
      t_reset();
      give_verdict(0);
   end
endmodule
